// ### ppa_label_filter.sv
// Path signal label filter: accepts a C2 value after a run of identical frames.
module ppa_label_filter
  import ppa_pkg::*;
#(
  parameter int WIDTH = 8
) (
  input  wire logic             clock,
  input  wire logic             reset,
  input  wire logic             frame_tick,
  input  wire logic [WIDTH-1:0] c2_byte,
  input  wire logic             label_filter_length,
  output logic      [WIDTH-1:0] label,
  output logic                  label_changed
);
  `include "ppa_map.svh"

  typedef struct packed {
    logic [WIDTH-1:0] cand;
    logic [2:0]       run;
    logic [WIDTH-1:0] label;
    logic             changed;
  } ppa_filt_state_t;

  ppa_filt_state_t st_reg;
  ppa_filt_state_t st_next;
  logic [2:0]      need;

  always_comb begin
    st_next         = st_reg;
    st_next.changed = 1'b0;
    need = label_filter_length ? `PPA_LABEL_LONG : `PPA_LABEL_SHORT;
    if (frame_tick) begin
      if (c2_byte != st_reg.cand) begin
        st_next.cand = c2_byte;
        st_next.run  = 3'h1;
      end else if (st_reg.run < need) begin
        st_next.run = st_reg.run + 3'h1;
      end
      if (st_next.run >= need && st_next.cand != st_reg.label) begin
        st_next.label   = st_next.cand;
        st_next.changed = 1'b1;
      end
    end
  end

  always_ff @(posedge clock or posedge reset) begin
    if (reset) begin
      st_reg <= '0;
    end else begin
      st_reg <= st_next;
    end
  end

  assign label         = st_reg.label;
  assign label_changed = st_reg.changed;

  label_filter_a: assert property (@(posedge clock) disable iff (reset)
    label_changed |-> $past(frame_tick))
    else $error("Label changed without a frame.");
endmodule

// ### ppa_map.svh
// Register offsets, field positions, reset values and filter counts of the path alarm registers.
`ifndef PPA_MAP_SVH
`define PPA_MAP_SVH

// ************************************************************
// Register indices and byte addresses
// ************************************************************
`define PPA_IDX_STATUS_CTRL   8'h30
`define PPA_IDX_IRQ_STATUS    8'h31
`define PPA_IDX_IRQ_ENABLE    8'h33
`define PPA_IDX_POINTER_MSB   8'h36
`define PPA_IDX_EVENT_IN      8'h3F
`define PPA_IDX_LABEL         8'h3E
`define PPA_ADDR_OF(idx)      ({(idx), 2'b00})

// ************************************************************
// Field positions
// ************************************************************
`define PPA_BIT_NEWPTR_EN     0
`define PPA_BIT_NEWPTR_ST     1
`define PPA_BIT_RDI           2
`define PPA_BIT_AIS           3
`define PPA_BIT_LOP           5
`define PPA_BIT_FEBE          0
`define PPA_BIT_PARITY        1
`define PPA_BIT_LABEL         7
`define PPA_BIT_INV_MODE      6
`define PPA_BIT_FILT_LEN      5
`define PPA_BIT_SHADOW_SEL    6
`define PPA_BIT_ERDI_EV       0
`define PPA_MASK_IRQ_ENABLE   8'hAF
`define PPA_MASK_SHADOW_CTRL  8'h60

// ************************************************************
// Reset values and counts
// ************************************************************
`define PPA_RESET_BYTE        8'h00
`define PPA_LABEL_LONG        3'h5
`define PPA_LABEL_SHORT       3'h3
`define PPA_NEWPTR_REPEAT     2'h3

`endif

// ### ppa_path_regs.sv
// APB register bank for path pointer, alarm and event status.
module ppa_path_regs
  import ppa_pkg::*;
#(
  parameter int INV_COUNT_WIDTH = 4
) (
  input  wire logic                       clock,
  input  wire logic                       reset,
  input  wire logic                       psel,
  input  wire logic                       penable,
  input  wire logic                       pwrite,
  input  wire logic [9:0]                 paddr,
  input  wire logic [31:0]                pwdata,
  input  wire logic [3:0]                 pstrb,
  output logic      [31:0]                prdata,
  output logic                            pready,
  output logic                            pslverr,
  input  wire ppa_path_in_t               path_in,
  input  wire logic                       invalid_pointer,
  output logic      [INV_COUNT_WIDTH-1:0] invalid_count,
  output logic                            irq
);
  `include "ppa_map.svh"

  localparam logic [9:0] A_STAT = `PPA_ADDR_OF(`PPA_IDX_STATUS_CTRL);
  localparam logic [9:0] A_IRQS = `PPA_ADDR_OF(`PPA_IDX_IRQ_STATUS);
  localparam logic [9:0] A_IRQE = `PPA_ADDR_OF(`PPA_IDX_IRQ_ENABLE);
  localparam logic [9:0] A_PMSB = `PPA_ADDR_OF(`PPA_IDX_POINTER_MSB);
  localparam logic [9:0] A_LABL = `PPA_ADDR_OF(`PPA_IDX_LABEL);

  // ************************************************************
  // State
  // ************************************************************
  typedef struct packed {
    ppa_bus_state_t             bus;
    logic [31:0]                rdata;
    logic                       slverr;
    logic                       ready;
    logic                       shadow_select;
    logic [7:0]                 pmsb_ctrl;
    logic [7:0]                 ctrl_normal;
    logic [7:0]                 ctrl_shadow;
    logic [7:0]                 enable_normal;
    logic                       erdi_enable;
    logic                       newptr_st;
    logic [7:0]                 events;
    logic                       erdi_event;
    logic                       rdi_q;
    logic                       rdi_aux_q;
    logic                       ais_q;
    logic                       lop_q;
    logic [2:0]                 erdi_q;
    logic [1:0]                 newptr_run;
    logic [INV_COUNT_WIDTH-1:0] inv_count;
    logic                       irq;
  } ppa_state_t;

  ppa_state_t s_reg;
  ppa_state_t s_next;
  logic [7:0] label;
  logic       label_changed;
  logic       label_filter_length;
  logic       rd_stat, rd_irqs, wr_any;
  logic [7:0] wbyte;
  logic [7:0] ev_set;

  assign label_filter_length = s_reg.ctrl_shadow[`PPA_BIT_FILT_LEN];

  ppa_label_filter #(
    .WIDTH(8)
  ) u_label (
    .clock              (clock),
    .reset              (reset),
    .frame_tick         (path_in.frame_tick),
    .c2_byte            (path_in.c2_byte),
    .label_filter_length(label_filter_length),
    .label              (label),
    .label_changed      (label_changed)
  );

  function automatic logic [31:0] byte_word(input logic [7:0] b);
    byte_word = {24'h000000, b};
  endfunction

  // ************************************************************
  // Next state
  // ************************************************************
  always_comb begin
    s_next  = s_reg;
    rd_stat = 1'b0;
    rd_irqs = 1'b0;
    wr_any  = 1'b0;
    wbyte   = pstrb[0] ? pwdata[7:0] : `PPA_RESET_BYTE;
    ev_set  = 8'h00;
    s_next.ready = 1'b0;
    s_next.slverr = 1'b0;

    // Event capture; a set in the same cycle as a read-clear wins.
    ev_set[`PPA_BIT_FEBE]   = path_in.febe;
    ev_set[`PPA_BIT_PARITY] = path_in.parity_err;
    ev_set[`PPA_BIT_RDI]    = (path_in.rdi != s_reg.rdi_q)
                            | (path_in.rdi_aux != s_reg.rdi_aux_q);
    ev_set[`PPA_BIT_AIS]    = path_in.ais != s_reg.ais_q;
    ev_set[`PPA_BIT_LOP]    = path_in.lop != s_reg.lop_q;
    ev_set[`PPA_BIT_LABEL]  = label_changed;
    s_next.rdi_q     = path_in.rdi;
    s_next.rdi_aux_q = path_in.rdi_aux;
    s_next.ais_q     = path_in.ais;
    s_next.lop_q     = path_in.lop;
    s_next.erdi_q    = path_in.erdi;

    // Invalid pointer counter with optional reset by repeated new pointers in LOP.
    if (invalid_pointer) begin
      s_next.inv_count = s_reg.inv_count + 1'b1;
    end
    if (path_in.new_pointer && path_in.lop) begin
      if (s_reg.newptr_run == `PPA_NEWPTR_REPEAT - 2'h1) begin
        s_next.newptr_run = 2'h0;
        if (s_reg.ctrl_shadow[`PPA_BIT_INV_MODE]) begin
          s_next.inv_count = '0;
        end
      end else begin
        s_next.newptr_run = s_reg.newptr_run + 2'h1;
      end
    end else if (!path_in.lop) begin
      s_next.newptr_run = 2'h0;
    end

    // APB slave: one wait state, answer in the DONE cycle.
    case (s_reg.bus)
      PPA_IDLE: begin
        if (psel && !penable) begin
          s_next.bus = PPA_ACCESS;
        end
      end
      PPA_ACCESS: begin
        s_next.bus    = PPA_DONE;
        s_next.ready  = 1'b1;
        s_next.slverr = 1'b0;
        s_next.rdata  = 32'h0000_0000;
        wr_any = pwrite;
        if (paddr == A_STAT) begin
          if (s_reg.shadow_select) begin
            s_next.rdata = byte_word(s_reg.ctrl_shadow | {5'h00, s_reg.erdi_q});
            if (wr_any) s_next.ctrl_shadow = wbyte & `PPA_MASK_SHADOW_CTRL;
          end else begin
            rd_stat = !pwrite;
            s_next.rdata = byte_word({s_reg.ctrl_normal[7], 1'b0, s_reg.lop_q, 1'b0,
                s_reg.ais_q, s_reg.rdi_q, s_reg.newptr_st,
                s_reg.ctrl_normal[`PPA_BIT_NEWPTR_EN]});
            if (wr_any) s_next.ctrl_normal = wbyte & 8'h81;
          end
        end else if (paddr == A_IRQS) begin
          rd_irqs = !pwrite;
          s_next.rdata = s_reg.shadow_select ? byte_word({7'h00, s_reg.erdi_event})
                                             : byte_word(s_reg.events);
        end else if (paddr == A_IRQE) begin
          if (s_reg.shadow_select) begin
            s_next.rdata = byte_word({7'h00, s_reg.erdi_enable});
            if (wr_any) s_next.erdi_enable = wbyte[0];
          end else begin
            s_next.rdata = byte_word(s_reg.enable_normal);
            if (wr_any) s_next.enable_normal = wbyte & `PPA_MASK_IRQ_ENABLE;
          end
        end else if (paddr == A_PMSB) begin
          s_next.rdata = byte_word({s_reg.pmsb_ctrl[7], s_reg.shadow_select,
                                    s_reg.pmsb_ctrl[5], 5'h00});
          if (wr_any) begin
            s_next.pmsb_ctrl     = wbyte & 8'hA0;
            s_next.shadow_select = wbyte[`PPA_BIT_SHADOW_SEL];
          end
        end else if (paddr == A_LABL) begin
          s_next.rdata = byte_word(label);
        end else begin
          s_next.slverr = 1'b1;
        end
      end
      PPA_DONE: begin
        s_next.bus = PPA_IDLE;
      end
      default: begin
        s_next.bus = PPA_IDLE;
      end
    endcase

    s_next.newptr_st  = path_in.new_pointer | (s_reg.newptr_st & !rd_stat);
    s_next.events     = ev_set | (s_reg.events & {8{!(rd_irqs && !s_reg.shadow_select)}});
    s_next.erdi_event = (path_in.erdi != s_reg.erdi_q)
                      | (s_reg.erdi_event & !(rd_irqs && s_reg.shadow_select));
    s_next.irq = (s_next.newptr_st & s_next.ctrl_normal[`PPA_BIT_NEWPTR_EN])
               | (|(s_next.events & s_next.enable_normal))
               | (s_next.erdi_event & s_next.erdi_enable);
  end

  always_ff @(posedge clock or posedge reset) begin
    if (reset) begin
      s_reg     <= '0;
      s_reg.bus <= PPA_IDLE;
    end else begin
      s_reg <= s_next;
    end
  end

  assign prdata        = s_reg.rdata;
  assign pready        = s_reg.ready;
  assign pslverr       = s_reg.slverr;
  assign invalid_count = s_reg.inv_count;
  assign irq           = s_reg.irq;

  // ************************************************************
  // Assertions
  // ************************************************************
  sequence newptr_seen_s;
    path_in.new_pointer ##1 1'b1;
  endsequence

  newptr_status_a: assert property (@(posedge clock) disable iff (reset)
    newptr_seen_s |-> s_reg.newptr_st) else $error("New pointer not latched.");
  rdi_mirror_a: assert property (@(posedge clock) disable iff (reset)
    ##1 s_reg.rdi_q == $past(path_in.rdi)) else $error("RDI state wrong.");
  ais_event_a: assert property (@(posedge clock) disable iff (reset)
    $changed(path_in.ais) |=> s_reg.events[3]) else $error("AIS event lost.");
  lop_event_a: assert property (@(posedge clock) disable iff (reset)
    $changed(path_in.lop) |=> s_reg.events[5]) else $error("LOP event lost.");
  febe_event_a: assert property (@(posedge clock) disable iff (reset)
    path_in.febe |=> s_reg.events[0]) else $error("FEBE event lost.");
  parity_event_a: assert property (@(posedge clock) disable iff (reset)
    path_in.parity_err |=> s_reg.events[1]) else $error("Parity event lost.");
  irq_gate_a: assert property (@(posedge clock) disable iff (reset)
    (|(s_reg.events & s_reg.enable_normal)) |-> irq) else $error("Irq missing.");
  enable_gate_a: assert property (@(posedge clock) disable iff (reset)
    (s_reg.enable_normal == 8'h00 && !s_reg.erdi_enable
     && !s_reg.ctrl_normal[0]) |-> !irq) else $error("Irq while masked.");
  erdi_event_a: assert property (@(posedge clock) disable iff (reset)
    (path_in.erdi != s_reg.erdi_q) |=> s_reg.erdi_event)
    else $error("Enhanced RDI event lost.");
  apb_answer_a: assert property (@(posedge clock) disable iff (reset)
    (psel && !penable && s_reg.bus == PPA_IDLE) |-> ##2 pready)
    else $error("APB answer late.");

  // A setup taken while idle, ending at the access edge that does the work.
  sequence status_read_s;
    (psel && !penable && !pwrite && paddr == A_STAT && s_reg.bus == PPA_IDLE) ##1 1'b1;
  endsequence

  sequence event_read_s;
    (psel && !penable && !pwrite && paddr == A_IRQS && s_reg.bus == PPA_IDLE) ##1 1'b1;
  endsequence

  sequence pmsb_write_s;
    (psel && !penable && pwrite && paddr == A_PMSB && s_reg.bus == PPA_IDLE) ##1 1'b1;
  endsequence

  rdi_readback_a: assert property (@(posedge clock) disable iff (reset)
    (status_read_s ##0 !s_reg.shadow_select) |=> prdata[2] == $past(s_reg.rdi_q))
    else $error("RDI state not shown.");
  ais_readback_a: assert property (@(posedge clock) disable iff (reset)
    (status_read_s ##0 !s_reg.shadow_select) |=> prdata[3] == $past(s_reg.ais_q))
    else $error("AIS state not shown.");
  lop_readback_a: assert property (@(posedge clock) disable iff (reset)
    (status_read_s ##0 !s_reg.shadow_select) |=> prdata[5] == $past(s_reg.lop_q))
    else $error("LOP state not shown.");
  erdi_readback_a: assert property (@(posedge clock) disable iff (reset)
    (status_read_s ##0 s_reg.shadow_select) |=> prdata[2:0] == $past(s_reg.erdi_q))
    else $error("Enhanced RDI state not shown.");
  newptr_clear_a: assert property (@(posedge clock) disable iff (reset)
    (status_read_s ##0 !s_reg.shadow_select)
    |=> (!s_reg.newptr_st || $past(path_in.new_pointer)))
    else $error("New pointer status not cleared.");
  febe_clear_a: assert property (@(posedge clock) disable iff (reset)
    (event_read_s ##0 !s_reg.shadow_select)
    |=> (!s_reg.events[0] || $past(path_in.febe)))
    else $error("FEBE event not cleared.");
  rdi_event_a: assert property (@(posedge clock) disable iff (reset)
    ($changed(path_in.rdi) || $changed(path_in.rdi_aux)) |=> s_reg.events[2])
    else $error("RDI event lost.");
  label_event_a: assert property (@(posedge clock) disable iff (reset)
    label_changed |=> s_reg.events[7]) else $error("Label event lost.");
  select_write_a: assert property (@(posedge clock) disable iff (reset)
    pmsb_write_s |=> s_reg.shadow_select == $past(pwdata[6] & pstrb[0]))
    else $error("Shadow select not written.");
  count_reset_a: assert property (@(posedge clock) disable iff (reset)
    (path_in.new_pointer && path_in.lop && s_reg.ctrl_shadow[6]
     && s_reg.newptr_run == 2'h2) |=> invalid_count == '0)
    else $error("Invalid count not reset.");
  count_keep_a: assert property (@(posedge clock) disable iff (reset)
    (path_in.new_pointer && path_in.lop && !s_reg.ctrl_shadow[6] && !invalid_pointer)
    |=> $stable(invalid_count)) else $error("Invalid count changed.");
  newptr_irq_a: assert property (@(posedge clock) disable iff (reset)
    (s_reg.newptr_st && s_reg.ctrl_normal[0]) |-> irq)
    else $error("New pointer irq missing.");
  ready_pulse_a: assert property (@(posedge clock) disable iff (reset)
    pready |=> !pready) else $error("Ready held too long.");
endmodule

// ### ppa_path_regs_bench.sv
// Self-checking bench for the path alarm register bank over APB.
`include "ppa_map.svh"
module ppa_path_regs_bench;
  import ppa_pkg::*;
  timeunit 1ns;
  timeprecision 1ps;

  logic         clock = 1'b0;
  logic         reset = 1'b1;
  logic         psel = 1'b0;
  logic         penable = 1'b0;
  logic         pwrite = 1'b0;
  logic [9:0]   paddr = 10'h000;
  logic [31:0]  pwdata = 32'h0000_0000;
  logic [3:0]   pstrb = 4'hF;
  logic [31:0]  prdata;
  logic         pready;
  logic         pslverr;
  ppa_path_in_t path_in;
  logic         invalid_pointer;
  logic [3:0]   invalid_count;
  logic         irq;
  int           fails = 0;
  int           checks_done = 0;
  logic [7:0]   rd;
  logic         err;

  always #5 clock = ~clock;

  ppa_path_source i_ppa_path_source (
    .clock           (clock),
    .path_in         (path_in),
    .invalid_pointer (invalid_pointer)
  );

  ppa_path_regs #(.INV_COUNT_WIDTH(4)) i_ppa_path_regs (
    .clock (clock), .reset (reset), .psel (psel), .penable (penable),
    .pwrite (pwrite), .paddr (paddr), .pwdata (pwdata), .pstrb (pstrb),
    .prdata (prdata), .pready (pready), .pslverr (pslverr), .path_in (path_in),
    .invalid_pointer (invalid_pointer), .invalid_count (invalid_count), .irq (irq)
  );

  task automatic print_verdict;
    if (fails == 0 && checks_done > 0) begin
      $display("== PASSED ==");
    end else begin
      $display("== FAILED ==");
    end
    $finish;
  endtask

  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    checks_done++;
    if (got !== exp) begin
      fails++;
      $display("Error at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  task automatic apb(input logic wr, input logic [7:0] idx, input logic [7:0] wd);
    int n;
    n = 0;
    @(posedge clock);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= wr;
    paddr <= `PPA_ADDR_OF(idx);
    pwdata <= {~wd, ~wd, ~wd, wd};
    @(posedge clock);
    penable <= 1'b1;
    do begin
      @(posedge clock);
      n++;
    end while (pready !== 1'b1 && n < 20);
    if (n >= 20) chk(8'h00, 8'hFF);
    rd = prdata[7:0];
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask

  task automatic rchk(input logic [7:0] idx, input logic [7:0] m, input logic [7:0] exp);
    apb(1'b0, idx, 8'h00);
    chk(rd & m, exp);
  endtask

  task automatic irq_chk(input logic exp);
    repeat (3) @(posedge clock);
    chk({7'h00, irq}, {7'h00, exp});
  endtask

  // Waits one edge so that a count updated at the last edge is visible.
  task automatic cnt_chk(input logic [3:0] exp);
    @(posedge clock);
    chk({4'h0, invalid_count}, {4'h0, exp});
  endtask

  initial begin
    #100us;
    fails++;
    print_verdict();
  end

  initial begin
    repeat (12) @(posedge clock);
    reset <= 1'b0;
    rchk(`PPA_IDX_STATUS_CTRL, 8'hFF, 8'h00);
    rchk(`PPA_IDX_IRQ_ENABLE, 8'hFF, 8'h00);
    rchk(`PPA_IDX_POINTER_MSB, 8'hE0, 8'h00);
    apb(1'b0, 8'h3A, 8'h00);
    chk({7'h00, err}, 8'h01);
    i_ppa_path_source.levels(4'hB, 3'h0);
    rchk(`PPA_IDX_STATUS_CTRL, 8'hFF, 8'h2C);
    rchk(`PPA_IDX_IRQ_STATUS, 8'hFF, 8'h2C);
    rchk(`PPA_IDX_IRQ_STATUS, 8'hFF, 8'h00);
    i_ppa_path_source.levels(4'hF, 3'h0);
    rchk(`PPA_IDX_IRQ_STATUS, 8'hFF, 8'h04);
    i_ppa_path_source.levels(4'h0, 3'h0);
    rchk(`PPA_IDX_STATUS_CTRL, 8'hFF, 8'h00);
    rchk(`PPA_IDX_IRQ_STATUS, 8'hFF, 8'h2C);
    i_ppa_path_source.pulse(2'h1);
    i_ppa_path_source.pulse(2'h2);
    irq_chk(1'b0);
    rchk(`PPA_IDX_IRQ_STATUS, 8'hFF, 8'h03);
    apb(1'b1, `PPA_IDX_IRQ_ENABLE, 8'h01);
    i_ppa_path_source.pulse(2'h2);
    irq_chk(1'b0);
    i_ppa_path_source.pulse(2'h1);
    irq_chk(1'b1);
    rchk(`PPA_IDX_IRQ_STATUS, 8'hFF, 8'h03);
    irq_chk(1'b0);
    pstrb <= 4'hE;
    apb(1'b1, `PPA_IDX_IRQ_ENABLE, 8'h01);
    pstrb <= 4'hF;
    rchk(`PPA_IDX_IRQ_ENABLE, 8'hFF, 8'h00);
    apb(1'b1, `PPA_IDX_STATUS_CTRL, 8'h01);
    i_ppa_path_source.pulse(2'h0);
    irq_chk(1'b1);
    rchk(`PPA_IDX_STATUS_CTRL, 8'h03, 8'h03);
    rchk(`PPA_IDX_STATUS_CTRL, 8'h03, 8'h01);
    irq_chk(1'b0);
    apb(1'b1, `PPA_IDX_STATUS_CTRL, 8'h00);
    apb(1'b1, `PPA_IDX_POINTER_MSB, 8'h40);
    rchk(`PPA_IDX_POINTER_MSB, 8'hE0, 8'h40);
    i_ppa_path_source.levels(4'h0, 3'h5);
    rchk(`PPA_IDX_STATUS_CTRL, 8'h07, 8'h05);
    rchk(`PPA_IDX_IRQ_STATUS, 8'hFF, 8'h01);
    rchk(`PPA_IDX_IRQ_STATUS, 8'hFF, 8'h00);
    apb(1'b1, `PPA_IDX_IRQ_ENABLE, 8'h01);
    i_ppa_path_source.levels(4'h0, 3'h2);
    irq_chk(1'b1);
    rchk(`PPA_IDX_IRQ_STATUS, 8'hFF, 8'h01);
    apb(1'b1, `PPA_IDX_IRQ_ENABLE, 8'h00);
    apb(1'b1, `PPA_IDX_STATUS_CTRL, 8'h60);
    rchk(`PPA_IDX_STATUS_CTRL, 8'h60, 8'h60);
    i_ppa_path_source.frames(8'hAA, 4);
    rchk(`PPA_IDX_LABEL, 8'hFF, 8'h00);
    i_ppa_path_source.frames(8'hAA, 1);
    rchk(`PPA_IDX_LABEL, 8'hFF, 8'hAA);
    repeat (3) i_ppa_path_source.pulse(2'h3);
    cnt_chk(4'h3);
    i_ppa_path_source.levels(4'h1, 3'h2);
    repeat (3) i_ppa_path_source.pulse(2'h0);
    irq_chk(1'b0);
    cnt_chk(4'h0);
    i_ppa_path_source.levels(4'h0, 3'h2);
    apb(1'b1, `PPA_IDX_STATUS_CTRL, 8'h00);
    repeat (2) i_ppa_path_source.pulse(2'h3);
    i_ppa_path_source.levels(4'h1, 3'h2);
    repeat (3) i_ppa_path_source.pulse(2'h0);
    irq_chk(1'b0);
    cnt_chk(4'h2);
    i_ppa_path_source.frames(8'h55, 2);
    rchk(`PPA_IDX_LABEL, 8'hFF, 8'hAA);
    i_ppa_path_source.frames(8'h55, 1);
    rchk(`PPA_IDX_LABEL, 8'hFF, 8'h55);
    apb(1'b1, `PPA_IDX_POINTER_MSB, 8'h00);
    rchk(`PPA_IDX_IRQ_STATUS, 8'h80, 8'h80);
    rchk(`PPA_IDX_IRQ_STATUS, 8'h80, 8'h00);
    print_verdict();
  end
endmodule

// ### ppa_path_source.sv
// Upstream path overhead source model that feeds events, levels and frames.
module ppa_path_source
  import ppa_pkg::*;
(
  input  wire logic   clock,
  output ppa_path_in_t path_in,
  output logic         invalid_pointer
);
  timeunit 1ns;
  timeprecision 1ps;

  initial begin
    path_in = '0;
    invalid_pointer = 1'b0;
  end

  // Kind 0 new pointer, 1 path FEBE, 2 B3 parity error, 3 invalid pointer.
  task automatic pulse(input logic [1:0] kind);
    @(posedge clock);
    path_in.new_pointer <= (kind == 2'h0);
    path_in.febe <= (kind == 2'h1);
    path_in.parity_err <= (kind == 2'h2);
    invalid_pointer <= (kind == 2'h3);
    @(posedge clock);
    path_in.new_pointer <= 1'b0;
    path_in.febe <= 1'b0;
    path_in.parity_err <= 1'b0;
    invalid_pointer <= 1'b0;
  endtask

  task automatic levels(input logic [3:0] lv, input logic [2:0] erdi);
    @(posedge clock);
    {path_in.rdi, path_in.rdi_aux, path_in.ais, path_in.lop} <= lv;
    path_in.erdi <= erdi;
  endtask

  // The label byte is only valid with the frame tick, so it is inverted in between.
  task automatic frames(input logic [7:0] c2, input int n);
    repeat (n) begin
      @(posedge clock);
      path_in.c2_byte <= c2;
      path_in.frame_tick <= 1'b1;
      @(posedge clock);
      path_in.c2_byte <= ~c2;
      path_in.frame_tick <= 1'b0;
    end
  endtask
endmodule

// ### ppa_pkg.sv
// Types shared by the path alarm register block.
package ppa_pkg;

  typedef struct packed {
    logic       new_pointer;
    logic       febe;
    logic       parity_err;
    logic       frame_tick;
    logic [7:0] c2_byte;
    logic       rdi;
    logic       rdi_aux;
    logic       ais;
    logic       lop;
    logic [2:0] erdi;
  } ppa_path_in_t;

  typedef enum logic [2:0] {
    PPA_IDLE   = 3'b001,
    PPA_ACCESS = 3'b010,
    PPA_DONE   = 3'b100
  } ppa_bus_state_t;

endpackage
